/* File: verilog/exec_slice_pkg.sv */
/*
 * Shared types and constants for the instruction execution slice.
 * Assumes a decoder upstream that supplies fetched operands and effective addresses.
 */
package exec_slice_pkg;
	typedef enum logic [4:0] {
		OP_SWAP = 5'h00, OP_WIDEN_W = 5'h01, OP_WIDEN_L = 5'h02, OP_WIDEN_BL = 5'h03,
		OP_FMAG = 5'h04, OP_FNEG = 5'h05, OP_FROOT = 5'h06, OP_FADD = 5'h07,
		OP_FSUB = 5'h08, OP_FMUL = 5'h09, OP_FDIV = 5'h0a, OP_FSGLMUL = 5'h0b,
		OP_FSGLDIV = 5'h0c, OP_FCMP = 5'h0d, OP_FTEST = 5'h0e, OP_FMOVE = 5'h0f,
		OP_FNOP = 5'h10, OP_FLOOP = 5'h11, OP_FSETC = 5'h12, OP_FCTRAP = 5'h13,
		OP_FCTX_ST = 5'h14, OP_FCTX_LD = 5'h15, OP_FMULTI = 5'h16, OP_UNDEF = 5'h17,
		OP_JUMP = 5'h18, OP_CALL = 5'h19, OP_LEA = 5'h1a, OP_LINK = 5'h1b
	} op_e;
	typedef enum logic [1:0] {TRAP_NONE = 2'h0, TRAP_FCOND = 2'h1, TRAP_PRIV = 2'h2} trap_e;
	typedef struct packed {
		logic valid;
		op_e op;
		logic [3:0] rx;
		logic [3:0] ry;
		logic src_mem;
		logic [31:0] src_val;
		logic [31:0] ea;
		logic [31:0] disp;
		logic cond_true;
		logic supervisor;
		logic [31:0] pc_ret;
		logic [15:0] sr;
		logic [7:0] list;
		logic list_dyn;
		logic ctrl_regs;
		logic to_mem;
	} cmd_s;
	typedef struct packed {
		logic req;
		logic we;
		logic [2:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_s;
	typedef struct packed {
		logic req;
		op_e fn;
		logic single;
		logic [31:0] a;
		logic [31:0] b;
	} fpu_s;
	localparam logic [2:0] SZ_B = 3'h1;
	localparam logic [2:0] SZ_W = 3'h2;
	localparam logic [2:0] SZ_L = 3'h4;
	localparam logic [31:0] STEP_L = 32'h0000_0004;
	localparam logic [31:0] STEP_W = 32'h0000_0002;
	localparam logic [31:0] ILL_VEC_ADDR = 32'h0000_0010;
	localparam logic [15:0] ILL_VEC_OFF = 16'h0010;
	localparam logic [15:0] LOOP_END = 16'hffff;
	localparam logic [3:0] SP_IDX = 4'hf;
	localparam int FCC_LSB = 24;
	localparam int FCC_N = 3;
	localparam int FCC_Z = 2;
	localparam int FCC_I = 1;
	localparam int FCC_NAN = 0;
	localparam int STAT_REG = 1;
	localparam logic [7:0] EXP_ONES = 8'hff;
endpackage : exec_slice_pkg

/* File: verilog/isa_exec_swap_to_frame_slice.sv */
/*
 * Execution unit for register swap, sign widening, float arithmetic and control, traps, jumps, calls,
 * address load and frame open.
 * Assumes operands and effective addresses arrive decoded, memory accepts a request every cycle
 * and answers reads with mem_rvalid, and an arithmetic unit answers float requests with fpu_done.
 */
`timescale 1ns/1ns
`default_nettype none
module isa_exec_swap_to_frame_slice
	import exec_slice_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire exec_slice_pkg::cmd_s cmd,
	input wire logic [4:0] rd_sel,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_rvalid,
	input wire logic fpu_done,
	input wire logic [31:0] fpu_result,
	output exec_slice_pkg::mem_s mem,
	output exec_slice_pkg::fpu_s fpu,
	output logic busy,
	output logic done,
	output logic trap,
	output exec_slice_pkg::trap_e trap_kind,
	output logic pc_load,
	output logic [31:0] pc_out,
	output logic [31:0] rd_data
);
	// ----------------------------------------
	// Reset release and state.
	// ----------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001, ST_PUSH = 6'b000010, ST_VEC = 6'b000100,
		ST_XFER = 6'b001000, ST_RD = 6'b010000, ST_FP = 6'b100000
	} state_e;
	logic rst_meta_r, rst_sync_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	state_e state_r, state_nxt;
	cmd_s cur_r, cur_nxt, c;
	logic [31:0] dreg_r [8], dreg_nxt [8];
	logic [31:0] areg_r [8], areg_nxt [8];
	logic [31:0] freg_r [8], freg_nxt [8];
	logic [31:0] fctl_r [3], fctl_nxt [3];
	logic [31:0] sup_sp_r, sup_sp_nxt, addr_r, addr_nxt;
	logic [7:0] list_r, list_nxt;
	logic [2:0] xidx_r, xidx_nxt;
	mem_s mem_nxt;
	fpu_s fpu_nxt;
	logic busy_nxt, done_nxt, trap_nxt, pc_load_nxt;
	trap_e trap_kind_nxt;
	logic [31:0] pc_nxt, rd_nxt;
	logic [1:0] gw_en;
	logic [3:0] gw_idx [2];
	logic [31:0] gw_val [2];
	function automatic logic [31:0] gpr(input logic [3:0] idx, input logic sup, input logic [31:0] d [8],
		input logic [31:0] a [8], input logic [31:0] sup_sp);
		if (idx == SP_IDX && sup)
			return sup_sp;
		return idx[3] ? a[idx[2:0]] : d[idx[2:0]];
	endfunction : gpr
	function automatic logic [3:0] fcc_of(input logic [31:0] v);
		logic [3:0] f;
		f = 4'h0;
		f[FCC_N] = v[31];
		f[FCC_Z] = (v[30:0] == 31'h0);
		f[FCC_I] = (v[30:23] == EXP_ONES) && (v[22:0] == 23'h0);
		f[FCC_NAN] = (v[30:23] == EXP_ONES) && (v[22:0] != 23'h0);
		return f;
	endfunction : fcc_of
	// ----------------------------------------
	// Next-state computation.
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] sp, src, tmp;
		logic [15:0] cnt;
		logic found;
		c = (state_r == ST_IDLE) ? cmd : cur_r;
		sp = gpr(SP_IDX, c.supervisor, dreg_r, areg_r, sup_sp_r);
		src = c.src_mem ? c.src_val : freg_r[c.ry[2:0]];
		tmp = 32'h0;
		cnt = 16'h0;
		found = 1'b0;
		state_nxt = state_r;
		cur_nxt = cur_r;
		dreg_nxt = dreg_r;
		areg_nxt = areg_r;
		freg_nxt = freg_r;
		fctl_nxt = fctl_r;
		sup_sp_nxt = sup_sp_r;
		addr_nxt = addr_r;
		list_nxt = list_r;
		xidx_nxt = xidx_r;
		mem_nxt = '0;
		fpu_nxt = '0;
		done_nxt = 1'b0;
		trap_nxt = 1'b0;
		trap_kind_nxt = trap_kind;
		pc_load_nxt = 1'b0;
		pc_nxt = pc_out;
		gw_en = 2'b00;
		gw_idx[0] = 4'h0;
		gw_idx[1] = 4'h0;
		gw_val[0] = 32'h0;
		gw_val[1] = 32'h0;
		unique case (state_r)
			ST_IDLE:
			begin
				if (cmd.valid)
				begin
					cur_nxt = cmd;
					done_nxt = 1'b1;
					unique case (cmd.op)
						OP_SWAP:
						begin
							gw_en = 2'b11;
							gw_idx[0] = cmd.rx;
							gw_val[0] = gpr(cmd.ry, cmd.supervisor, dreg_r, areg_r, sup_sp_r);
							gw_idx[1] = cmd.ry;
							gw_val[1] = gpr(cmd.rx, cmd.supervisor, dreg_r, areg_r, sup_sp_r);
						end
						OP_WIDEN_W:
							dreg_nxt[cmd.rx[2:0]][15:8] = {8{dreg_r[cmd.rx[2:0]][7]}};
						OP_WIDEN_L:
							dreg_nxt[cmd.rx[2:0]][31:16] = {16{dreg_r[cmd.rx[2:0]][15]}};
						OP_WIDEN_BL:
							dreg_nxt[cmd.rx[2:0]][31:8] = {24{dreg_r[cmd.rx[2:0]][7]}};
						OP_FMAG:
							freg_nxt[cmd.rx[2:0]] = {1'b0, src[30:0]};
						OP_FNEG:
							freg_nxt[cmd.rx[2:0]] = {~src[31], src[30:0]};
						OP_FMOVE:
							freg_nxt[cmd.rx[2:0]] = src;
						OP_FTEST:
							fctl_nxt[STAT_REG][FCC_LSB+:4] = fcc_of(src);
						OP_FNOP:
							done_nxt = 1'b1;
						OP_FROOT, OP_FADD, OP_FSUB, OP_FMUL, OP_FDIV, OP_FSGLMUL, OP_FSGLDIV, OP_FCMP:
						begin
							done_nxt = 1'b0;
							fpu_nxt = {1'b1, cmd.op, cmd.op == OP_FSGLMUL || cmd.op == OP_FSGLDIV,
								freg_r[cmd.rx[2:0]], src};
							state_nxt = ST_FP;
						end
						OP_FLOOP:
						begin
							if (!cmd.cond_true)
							begin
								cnt = dreg_r[cmd.rx[2:0]][15:0] - 16'h1;
								dreg_nxt[cmd.rx[2:0]][15:0] = cnt;
								pc_load_nxt = (cnt != LOOP_END);
								pc_nxt = cmd.pc_ret + cmd.disp;
							end
						end
						OP_FSETC:
						begin
							if (cmd.src_mem)
								mem_nxt = {1'b1, 1'b1, SZ_B, cmd.ea, {24'h0, {8{cmd.cond_true}}}};
							else
								dreg_nxt[cmd.rx[2:0]][7:0] = {8{cmd.cond_true}};
						end
						OP_FCTRAP:
						begin
							trap_nxt = cmd.cond_true;
							trap_kind_nxt = cmd.cond_true ? TRAP_FCOND : TRAP_NONE;
						end
						OP_FCTX_ST, OP_FCTX_LD:
						begin
							trap_nxt = !cmd.supervisor;
							trap_kind_nxt = cmd.supervisor ? TRAP_NONE : TRAP_PRIV;
							if (cmd.supervisor && cmd.op == OP_FCTX_ST)
								mem_nxt = {1'b1, 1'b1, SZ_L, cmd.ea, fctl_r[STAT_REG]};
							else if (cmd.supervisor)
							begin
								done_nxt = 1'b0;
								mem_nxt = {1'b1, 1'b0, SZ_L, cmd.ea, 32'h0};
								state_nxt = ST_RD;
							end
						end
						OP_FMULTI:
						begin
							done_nxt = 1'b0;
							list_nxt = cmd.list_dyn ? dreg_r[cmd.ry[2:0]][7:0] : cmd.list;
							addr_nxt = cmd.ea;
							state_nxt = ST_XFER;
						end
						OP_UNDEF:
						begin
							done_nxt = 1'b0;
							addr_nxt = 32'h0;
							sup_sp_nxt = sup_sp_r - STEP_W;
							mem_nxt = {1'b1, 1'b1, SZ_W, sup_sp_r - STEP_W, {16'h0, ILL_VEC_OFF}};
							state_nxt = ST_PUSH;
						end
						OP_JUMP:
						begin
							pc_load_nxt = 1'b1;
							pc_nxt = cmd.ea;
						end
						OP_CALL:
						begin
							mem_nxt = {1'b1, 1'b1, SZ_L, sp - STEP_L, cmd.pc_ret};
							gw_en = 2'b01;
							gw_idx[0] = SP_IDX;
							gw_val[0] = sp - STEP_L;
							pc_load_nxt = 1'b1;
							pc_nxt = cmd.ea;
						end
						OP_LEA:
						begin
							gw_en = 2'b01;
							gw_idx[0] = {1'b1, cmd.rx[2:0]};
							gw_val[0] = cmd.ea;
						end
						OP_LINK:
						begin
							mem_nxt = {1'b1, 1'b1, SZ_L, sp - STEP_L,
								gpr({1'b1, cmd.rx[2:0]}, cmd.supervisor, dreg_r, areg_r, sup_sp_r)};
							gw_en = 2'b11;
							gw_idx[0] = {1'b1, cmd.rx[2:0]};
							gw_val[0] = sp - STEP_L;
							gw_idx[1] = SP_IDX;
							gw_val[1] = sp - STEP_L + cmd.disp;
						end
						default:
							done_nxt = 1'b1;
					endcase
				end
			end
			ST_PUSH:
			begin
				if (addr_r == 32'h0)
				begin
					sup_sp_nxt = sup_sp_r - STEP_L;
					mem_nxt = {1'b1, 1'b1, SZ_L, sup_sp_r - STEP_L, c.pc_ret};
					addr_nxt = STEP_L;
				end
				else
				begin
					sup_sp_nxt = sup_sp_r - STEP_W;
					mem_nxt = {1'b1, 1'b1, SZ_W, sup_sp_r - STEP_W, {16'h0, c.sr}};
					addr_nxt = 32'h0;
					state_nxt = ST_VEC;
				end
			end
			ST_VEC:
			begin
				mem_nxt = {1'b1, 1'b0, SZ_L, ILL_VEC_ADDR, 32'h0};
				state_nxt = ST_RD;
			end
			ST_XFER:
			begin
				for (int i = 7; i >= 0; i--)
				begin
					if (list_r[i])
					begin
						found = 1'b1;
						xidx_nxt = 3'(i);
					end
				end
				if (!found)
				begin
					done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
				else
				begin
					list_nxt[xidx_nxt] = 1'b0;
					tmp = c.ctrl_regs ? fctl_r[xidx_nxt[1:0]] : freg_r[xidx_nxt];
					mem_nxt = {1'b1, c.to_mem, SZ_L, addr_r, c.to_mem ? tmp : 32'h0};
					if (c.to_mem)
						addr_nxt = addr_r + STEP_L;
					else
						state_nxt = ST_RD;
				end
			end
			ST_RD:
			begin
				if (mem_rvalid)
				begin
					if (c.op == OP_FMULTI)
					begin
						if (c.ctrl_regs)
							fctl_nxt[xidx_r[1:0]] = mem_rdata;
						else
							freg_nxt[xidx_r] = mem_rdata;
						addr_nxt = addr_r + STEP_L;
						state_nxt = ST_XFER;
					end
					else
					begin
						if (c.op == OP_FCTX_LD)
							fctl_nxt[STAT_REG] = mem_rdata;
						else
						begin
							pc_load_nxt = 1'b1;
							pc_nxt = mem_rdata;
						end
						done_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_FP:
			begin
				if (fpu_done)
				begin
					if (c.op != OP_FCMP)
						freg_nxt[c.rx[2:0]] = fpu_result;
					fctl_nxt[STAT_REG][FCC_LSB+:4] = fcc_of(fpu_result);
					done_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
		endcase
		for (int k = 0; k < 2; k++)
		begin
			if (gw_en[k])
			begin
				if (gw_idx[k] == SP_IDX && c.supervisor)
					sup_sp_nxt = gw_val[k];
				else if (gw_idx[k][3])
					areg_nxt[gw_idx[k][2:0]] = gw_val[k];
				else
					dreg_nxt[gw_idx[k][2:0]] = gw_val[k];
			end
		end
		busy_nxt = (state_nxt != ST_IDLE);
		unique case (rd_sel[4:3])
			2'h0: rd_nxt = dreg_r[rd_sel[2:0]];
			2'h1: rd_nxt = areg_r[rd_sel[2:0]];
			2'h2: rd_nxt = freg_r[rd_sel[2:0]];
			default: rd_nxt = rd_sel[0] ? sup_sp_r : fctl_r[STAT_REG];
		endcase
	end
	// ----------------------------------------
	// Registers.
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_sync_r)
	begin
		if (!rst_sync_r)
		begin
			state_r <= ST_IDLE;
			cur_r <= '0;
			for (int i = 0; i < 8; i++)
			begin
				dreg_r[i] <= 32'h0;
				areg_r[i] <= 32'h0;
				freg_r[i] <= 32'h0;
			end
			for (int i = 0; i < 3; i++)
				fctl_r[i] <= 32'h0;
			sup_sp_r <= 32'h0;
			addr_r <= 32'h0;
			list_r <= 8'h0;
			xidx_r <= 3'h0;
			mem <= '0;
			fpu <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			trap <= 1'b0;
			trap_kind <= TRAP_NONE;
			pc_load <= 1'b0;
			pc_out <= 32'h0;
			rd_data <= 32'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
			dreg_r <= dreg_nxt;
			areg_r <= areg_nxt;
			freg_r <= freg_nxt;
			fctl_r <= fctl_nxt;
			sup_sp_r <= sup_sp_nxt;
			addr_r <= addr_nxt;
			list_r <= list_nxt;
			xidx_r <= xidx_nxt;
			mem <= mem_nxt;
			fpu <= fpu_nxt;
			busy <= busy_nxt;
			done <= done_nxt;
			trap <= trap_nxt;
			trap_kind <= trap_kind_nxt;
			pc_load <= pc_load_nxt;
			pc_out <= pc_nxt;
			rd_data <= rd_nxt;
		end
	end
	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	wire go = state_r == ST_IDLE && cmd.valid;
	swap_data_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_SWAP && !cmd.rx[3] && !cmd.ry[3] |=>
		dreg_r[cur_r.rx[2:0]] == $past(dreg_r[cmd.ry[2:0]]) && dreg_r[cur_r.ry[2:0]] == $past(dreg_r[cmd.rx[2:0]]))
		else $error("swap did not exchange");
	widen_bl_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_WIDEN_BL |=> dreg_r[cur_r.rx[2:0]] == 32'($signed($past(dreg_r[cmd.rx[2:0]][7:0]))))
		else $error("byte to long widen wrong");
	mag_sign_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_FMAG |=> !freg_r[cur_r.rx[2:0]][31])
		else $error("magnitude kept sign");
	loop_exit_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_FLOOP |=> pc_load == (!cur_r.cond_true && dreg_r[cur_r.rx[2:0]][15:0] != LOOP_END))
		else $error("loop branch decision wrong");
	ftrap_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_FCTRAP |=> trap == cur_r.cond_true)
		else $error("conditional trap mismatch");
	priv_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && (cmd.op == OP_FCTX_ST || cmd.op == OP_FCTX_LD) && !cmd.supervisor |=>
		trap && trap_kind == TRAP_PRIV && !mem.req)
		else $error("user frame access not trapped");
	undef_seq_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_UNDEF |=> mem.size == SZ_W ##1 mem.size == SZ_L ##1 mem.size == SZ_W
		##1 (mem.req && !mem.we && mem.addr == ILL_VEC_ADDR))
		else $error("undefined trap stacking order wrong");
	jump_nopush_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_JUMP |=> pc_load && pc_out == $past(cmd.ea) && !mem.req)
		else $error("jump pushed or missed target");
	call_push_a: assert property (@(posedge clk) disable iff (!rst_sync_r)
		go && cmd.op == OP_CALL |=> mem.req && mem.we && mem.wdata == $past(cmd.pc_ret) && pc_out == $past(cmd.ea))
		else $error("call push wrong");
endmodule : isa_exec_swap_to_frame_slice
`default_nettype wire

/* File: dv/exec_far_model.sv */
/*
 * Far-side model: memory that answers reads and a float unit that answers requests.
 * Assumes at most one read and one float request outstanding, as the unit issues them.
 */
`timescale 1ns/1ns
`default_nettype none
module exec_far_model
(
	input wire logic clk,
	input wire logic slow,
	input wire exec_slice_pkg::mem_s mem,
	input wire exec_slice_pkg::fpu_s fpu,
	output logic [31:0] mem_rdata,
	output logic mem_rvalid,
	output logic fpu_done,
	output logic [31:0] fpu_result
);
	import exec_slice_pkg::*;
	logic [31:0] maddr_r;
	logic [31:0] fres_r;
	logic [2:0] mcnt_r;
	logic [2:0] fcnt_r;
	logic mpend_r;
	logic fpend_r;
	function automatic logic [31:0] fcalc(input fpu_s f);
		case (f.fn)
			OP_FMAG: fcalc = {1'b0, f.b[30:0]};
			OP_FNEG: fcalc = {~f.b[31], f.b[30:0]};
			OP_FMOVE: fcalc = f.b;
			default: fcalc = f.a ^ f.b ^ 32'h0f0f_0000;
		endcase
	endfunction : fcalc
	// ----------------------------------------
	// Answers; idle data lines flip every cycle.
	// ----------------------------------------
	initial
	begin
		mem_rdata = 32'h0;
		mem_rvalid = 1'b0;
		fpu_done = 1'b0;
		fpu_result = 32'h0;
		mpend_r = 1'b0;
		fpend_r = 1'b0;
	end
	always @(posedge clk)
	begin
		mem_rvalid <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem.req === 1'b1 && mem.we === 1'b0)
		begin
			mpend_r <= 1'b1;
			maddr_r <= mem.addr;
			mcnt_r <= slow ? 3'h3 : 3'h0;
		end
		else if (mpend_r && mcnt_r != 3'h0)
			mcnt_r <= mcnt_r - 3'h1;
		else if (mpend_r)
		begin
			mpend_r <= 1'b0;
			mem_rvalid <= 1'b1;
			mem_rdata <= ~maddr_r;
		end
	end
	always @(posedge clk)
	begin
		fpu_done <= 1'b0;
		fpu_result <= ~fpu_result;
		if (fpu.req === 1'b1)
		begin
			fpend_r <= 1'b1;
			fres_r <= fcalc(fpu);
			fcnt_r <= slow ? 3'h4 : 3'h0;
		end
		else if (fpend_r && fcnt_r != 3'h0)
			fcnt_r <= fcnt_r - 3'h1;
		else if (fpend_r)
		begin
			fpend_r <= 1'b0;
			fpu_done <= 1'b1;
			fpu_result <= fres_r;
		end
	end
endmodule : exec_far_model
`default_nettype wire

/* File: dv/isa_exec_swap_to_frame_slice_tb.sv */
/*
 * Self-checking bench for the execution slice.
 * Assumes the far-side model answers memory reads and float requests.
 */
`timescale 1ns/1ns
`default_nettype none
module isa_exec_swap_to_frame_slice_tb;
	import exec_slice_pkg::*;
	logic clk, rst_n, slow, mem_rvalid, fpu_done, busy, done, trap, pc_load;
	logic [4:0] rd_sel;
	logic [31:0] mem_rdata, fpu_result, pc_out, rd_data, sp;
	cmd_s cmd, k;
	mem_s mem;
	fpu_s fpu;
	trap_e trap_kind;
	int n_mismatch, checked;
	isa_exec_swap_to_frame_slice i_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rd_sel(rd_sel), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid), .fpu_done(fpu_done), .fpu_result(fpu_result), .mem(mem), .fpu(fpu), .busy(busy),
		.done(done), .trap(trap), .trap_kind(trap_kind), .pc_load(pc_load), .pc_out(pc_out), .rd_data(rd_data));
	exec_far_model i_far (.clk(clk), .slow(slow), .mem(mem), .fpu(fpu), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid), .fpu_done(fpu_done), .fpu_result(fpu_result));
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic end_sim();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cb(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : cb
	function automatic cmd_s mk(input op_e op, input logic [3:0] rx, input logic [3:0] ry, input logic [31:0] v);
		mk = '0;
		mk.op = op;
		mk.rx = rx;
		mk.ry = ry;
		mk.ea = v;
		mk.src_val = v;
		mk.src_mem = 1'b1;
		mk.supervisor = 1'b1;
	endfunction : mk
	task automatic go(input cmd_s c);
		c.valid = 1'b1;
		@(negedge clk);
		cmd = c;
		@(negedge clk);
		cmd.valid = 1'b0;
	endtask : go
	task automatic wt();
		int i;
		for (i = 0; i < 40 && done !== 1'b1; i++)
			@(negedge clk);
		if (done !== 1'b1)
		begin
			n_mismatch++;
			end_sim();
		end
	endtask : wt
	task automatic rc(input string what, input logic [4:0] sel, input logic [31:0] exp);
		rd_sel = sel;
		@(negedge clk);
		chk(what, exp, rd_data);
	endtask : rc
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_regs();
		go(mk(OP_LEA, 4'ha, 4'h0, 32'h1234_5680));
		cb("addr_done", 1'b1, done);
		go(mk(OP_LEA, 4'hb, 4'h0, 32'h0000_8001));
		rc("areg2", 5'h0a, 32'h1234_5680);
		go(mk(OP_SWAP, 4'ha, 4'h1, 32'h0));
		rc("dreg1", 5'h01, 32'h1234_5680);
		rc("areg2", 5'h0a, 32'h0);
		go(mk(OP_SWAP, 4'h2, 4'hb, 32'h0));
		rc("dreg2", 5'h02, 32'h0000_8001);
		go(mk(OP_WIDEN_W, 4'h1, 4'h0, 32'h0));
		rc("widen_w", 5'h01, 32'h1234_ff80);
		go(mk(OP_WIDEN_L, 4'h2, 4'h0, 32'h0));
		rc("widen_l", 5'h02, 32'hffff_8001);
		go(mk(OP_WIDEN_BL, 4'h1, 4'h0, 32'h0));
		rc("widen_bl", 5'h01, 32'hffff_ff80);
		go(mk(OP_SWAP, 4'h1, 4'h2, 32'h0));
		rc("swap_d1", 5'h01, 32'hffff_8001);
		rc("swap_d2", 5'h02, 32'hffff_ff80);
	endtask : t_regs
	task automatic t_flt();
		slow = 1'b1;
		go(mk(OP_FMOVE, 4'h1, 4'h0, 32'h4000_0000));
		wt();
		go(mk(OP_FMAG, 4'h2, 4'h0, 32'hc040_0000));
		wt();
		rc("magnitude", 5'h12, 32'h4040_0000);
		go(mk(OP_FADD, 4'h1, 4'h0, 32'h3f80_0000));
		cb("arith_req", 1'b1, fpu.req);
		chk("arith_fn", {27'h0, OP_FADD}, {27'h0, fpu.fn});
		chk("arith_a", 32'h4000_0000, fpu.a);
		chk("arith_b", 32'h3f80_0000, fpu.b);
		wt();
		rc("sum", 5'h11, 32'h708f_0000);
		k = mk(OP_FROOT, 4'h1, 4'h1, 32'h0);
		k.src_mem = 1'b0;
		go(k);
		chk("root_src", 32'h708f_0000, fpu.b);
		wt();
		rc("root", 5'h11, 32'h0f0f_0000);
		go(mk(OP_FCMP, 4'h1, 4'h0, 32'h1));
		wt();
		rc("cmp_keep", 5'h11, 32'h0f0f_0000);
		go(mk(OP_FTEST, 4'h2, 4'h2, 32'hbf80_0000));
		wt();
		rc("test_keep", 5'h12, 32'h4040_0000);
		rc("test_fcc", 5'h18, 32'h0800_0000);
		go(mk(OP_FSGLMUL, 4'h2, 4'h0, 32'h0));
		cb("single", 1'b1, fpu.single);
		wt();
		go(mk(OP_FNEG, 4'h3, 4'h0, 32'h3f80_0000));
		rc("negate", 5'h13, 32'hbf80_0000);
		go(mk(OP_FNOP, 4'h3, 4'h0, 32'h0));
		cb("nop_done", 1'b1, done);
		rc("nop_keep", 5'h13, 32'hbf80_0000);
		slow = 1'b0;
	endtask : t_flt
	task automatic t_cond();
		k = mk(OP_FSETC, 4'h4, 4'h0, 32'h0);
		k.src_mem = 1'b0;
		k.cond_true = 1'b1;
		go(k);
		rc("set_true", 5'h04, 32'h0000_00ff);
		k.cond_true = 1'b0;
		go(k);
		rc("set_false", 5'h04, 32'h0);
		k.src_mem = 1'b1;
		k.ea = 32'h9000;
		k.cond_true = 1'b1;
		go(k);
		chk("set_mem_addr", 32'h9000, mem.addr);
		chk("set_mem_data", 32'h0000_00ff, mem.wdata);
		k = mk(OP_FLOOP, 4'h5, 4'h0, 32'h0);
		k.disp = 32'h40;
		k.cond_true = 1'b1;
		go(k);
		cb("loop_idle", 1'b0, pc_load);
		k.cond_true = 1'b0;
		go(k);
		cb("loop_exit", 1'b0, pc_load);
		rc("loop_cnt", 5'h05, 32'h0000_ffff);
		go(k);
		cb("loop_branch", 1'b1, pc_load);
		chk("loop_pc", 32'h40, pc_out);
		rc("loop_cnt", 5'h05, 32'h0000_fffe);
		k = mk(OP_FCTRAP, 4'h0, 4'h0, 32'h0);
		k.cond_true = 1'b1;
		go(k);
		cb("ctrap", 1'b1, trap);
		chk("ctrap_kind", 32'h1, {30'h0, trap_kind});
		k.cond_true = 1'b0;
		go(k);
		cb("ctrap_none", 1'b0, trap);
	endtask : t_cond
	task automatic t_priv();
		k = mk(OP_FCTX_ST, 4'h0, 4'h0, 32'h8000);
		k.supervisor = 1'b0;
		go(k);
		cb("user_store", 1'b1, trap);
		chk("user_kind", 32'h2, {30'h0, trap_kind});
		cb("user_store_mem", 1'b0, mem.req);
		k.op = OP_FCTX_LD;
		go(k);
		cb("user_load", 1'b1, trap);
		cb("user_load_mem", 1'b0, mem.req);
		k.supervisor = 1'b1;
		go(k);
		cb("load_rd", 1'b0, mem.we);
		chk("load_addr", 32'h8000, mem.addr);
		wt();
		k.op = OP_FCTX_ST;
		go(k);
		cb("store_wr", 1'b1, mem.we);
		chk("store_data", 32'hffff_7fff, mem.wdata);
		wt();
	endtask : t_priv
	task automatic t_flow();
		go(mk(OP_JUMP, 4'h0, 4'h0, 32'h2000));
		cb("jump_load", 1'b1, pc_load);
		chk("jump_pc", 32'h2000, pc_out);
		cb("jump_mem", 1'b0, mem.req);
		k = mk(OP_CALL, 4'h0, 4'h0, 32'h3000);
		k.pc_ret = 32'h1004;
		go(k);
		sp = sp - 32'h4;
		chk("call_addr", sp, mem.addr);
		chk("call_data", 32'h1004, mem.wdata);
		chk("call_pc", 32'h3000, pc_out);
		k.op = OP_UNDEF;
		k.pc_ret = 32'h1100;
		k.sr = 16'h2700;
		go(k);
		chk("push_off", sp - 32'h2, mem.addr);
		chk("off", 32'h0010, {16'h0, mem.wdata[15:0]});
		@(negedge clk);
		chk("push_pc", sp - 32'h6, mem.addr);
		chk("pc", 32'h1100, mem.wdata);
		@(negedge clk);
		chk("push_sr", sp - 32'h8, mem.addr);
		chk("sr", 32'h2700, {16'h0, mem.wdata[15:0]});
		@(negedge clk);
		chk("vec_addr", 32'h10, mem.addr);
		sp = sp - 32'h8;
		wt();
		chk("vec_pc", 32'hffff_ffef, pc_out);
		rc("sstack", 5'h19, sp);
		go(mk(OP_LEA, 4'he, 4'h0, 32'h5000));
		k = mk(OP_LINK, 4'he, 4'h0, 32'h0);
		k.disp = 32'hffff_fff0;
		go(k);
		sp = sp - 32'h4;
		chk("frame_addr", sp, mem.addr);
		chk("frame_data", 32'h5000, mem.wdata);
		rc("frame_link", 5'h0e, sp);
		rc("frame_sp", 5'h19, sp - 32'h10);
	endtask : t_flow
	task automatic t_multi();
		logic [31:0] a[$];
		logic [31:0] d[$];
		int i;
		k = mk(OP_FMULTI, 4'h0, 4'h0, 32'h6000);
		k.list = 8'h03;
		go(k);
		wt();
		rc("list_in0", 5'h10, 32'hffff_9fff);
		rc("list_in1", 5'h11, 32'hffff_9ffb);
		k.to_mem = 1'b1;
		k.ea = 32'h7000;
		go(k);
		for (i = 0; i < 40 && done !== 1'b1; i++)
		begin
			if (mem.req === 1'b1)
			begin
				a.push_back(mem.addr);
				d.push_back(mem.wdata);
			end
			@(negedge clk);
		end
		wt();
		chk("list_cnt", 32'h2, a.size());
		chk("list_a0", 32'h7000, a[0]);
		chk("list_d0", 32'hffff_9fff, d[0]);
		chk("list_a1", 32'h7004, a[1]);
		chk("list_d1", 32'hffff_9ffb, d[1]);
	endtask : t_multi
	initial
	begin
		rst_n = 1'b0;
		slow = 1'b0;
		rd_sel = 5'h0;
		cmd = '0;
		k = '0;
		sp = 32'h0;
		n_mismatch = 0;
		checked = 0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		t_regs();
		t_flt();
		t_cond();
		t_priv();
		t_flow();
		t_multi();
		end_sim();
	end
endmodule : isa_exec_swap_to_frame_slice_tb
`default_nettype wire
